// ### hdl/keo_pkg.sv
// Package with the register map, field layout and reset values of the block.
package keo_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [10:0] KEO_IDX_READBACK  = 11'h4d5;
	localparam logic [10:0] KEO_IDX_OVERRIDE  = 11'h4d6;
	localparam logic [10:0] KEO_IDX_RSVD_LAST = 11'h4ff;
	localparam logic [31:0] KEO_ADDR_READBACK = {19'h0, KEO_IDX_READBACK, 2'b00};
	localparam logic [31:0] KEO_ADDR_OVERRIDE = {19'h0, KEO_IDX_OVERRIDE, 2'b00};

	// ------------------------------------------------------------------
	// Field widths
	// ------------------------------------------------------------------
	localparam int KEO_SWING_W = 5;
	localparam int KEO_POST_W  = 6;
	localparam int KEO_PRE_W   = 5;
	localparam int KEO_CTLE_W  = 4;
	localparam int KEO_MODE_W  = 2;

	// ------------------------------------------------------------------
	// Readback word fields (LSB positions)
	// ------------------------------------------------------------------
	localparam int KEO_RB_SWING_LSB = 0;
	localparam int KEO_RB_POST_LSB  = 8;
	localparam int KEO_RB_PRE_LSB   = 16;
	localparam int KEO_RB_CTLE_LSB  = 24;
	localparam int KEO_RB_LMODE_LSB = 28;
	localparam int KEO_RB_DFE_LSB   = 30;

	// ------------------------------------------------------------------
	// Override word fields (LSB positions)
	// ------------------------------------------------------------------
	localparam int KEO_OV_MAX_LSB  = 0;
	localparam int KEO_OV_MAX_EN   = 5;
	localparam int KEO_OV_MIN_LSB  = 8;
	localparam int KEO_OV_MIN_EN   = 13;
	localparam int KEO_OV_POST_LSB = 16;
	localparam int KEO_OV_POST_EN  = 22;
	localparam int KEO_OV_PRE_LSB  = 24;
	localparam int KEO_OV_PRE_EN   = 29;

	// ------------------------------------------------------------------
	// Reset values and bus encodings
	// ------------------------------------------------------------------
	localparam logic [31:0] KEO_OVERRIDE_RST = 32'h0000_0000;
	localparam logic [31:0] KEO_READBACK_RST = 32'h0000_0000;
	localparam logic [1:0]  KEO_HTRANS_NONSEQ = 2'h2;
	localparam logic        KEO_HRESP_OKAY    = 1'b0;

	// Default build-time limits; arbitrary plain values.
	localparam logic [4:0] KEO_CFG_MAX_SWING   = 5'h1f;
	localparam logic [4:0] KEO_CFG_MIN_SWING   = 5'h09;
	localparam logic [5:0] KEO_CFG_POST_CURSOR = 6'h1f;
	localparam logic [4:0] KEO_CFG_PRE_CURSOR  = 5'h0f;
	localparam logic [4:0] KEO_CFG_PRESET_MAIN = 5'h1f;

endpackage

// ### hdl/keo_lim_if.sv
// Interface carrying one override value, its enable and the chosen limit.
`timescale 1ns/1ps
`default_nettype none
interface keo_lim_if #(
	parameter int W = 5
);
	logic [W-1:0] ovrd;
	logic         en;
	logic [W-1:0] lim;

	modport ctl (output ovrd, output en, input lim);
	modport sel (input ovrd, input en, output lim);
endinterface
`default_nettype wire

// ### hdl/keo_limit_sel.sv
// Registered selection between a build-time limit and a software override.
`timescale 1ns/1ps
`default_nettype none
module keo_limit_sel
	import keo_pkg::*;
#(
	parameter int           W   = 5,
	parameter logic [W-1:0] CFG = '0
) (
	input wire logic hclk,    // Bus clock
	input wire logic hresetn, // Asynchronous reset, active low
	keo_lim_if.sel   lim      // Override in, chosen limit out
);
	logic [W-1:0] next_lim;
	logic [W-1:0] lim_q;

	// The stored value only counts while its enable is set.
	always_comb begin
		next_lim = lim.en ? lim.ovrd : CFG;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lim_q <= CFG;
		end else begin
			lim_q <= next_lim;
		end
	end

	assign lim.lim = lim_q;
endmodule
`default_nettype wire

// ### hdl/keo_regs.sv
// Register bank for equalization readback and transmit limit overrides.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Readback bits 27:24 hold the last linear equalizer setting sent out.
// - Readback bits 29:28 hold the last linear equalizer mode; read-only.
// - Readback bits 31:30 hold the last decision feedback mode; read-only.
// - The maximum swing override applies only while bit 5 is one.
// - An active maximum swing override also replaces the preset main tap.
// - Bits 12:8 hold minimum swing override, applied while bit 13 is one.
// - Bits 21:16 hold post-cursor override, applied while bit 22 is one.
// - Bits 28:24 hold pre-cursor limit override, applied while bit 29 is one.
// - Words after the override word up to 0x4ff hold no registers.
// - Readback bits 4:0 hold the last swing trained by the link partner.
module keo_regs
	import keo_pkg::*;
#(
	parameter logic [4:0] CFG_MAX_SWING   = KEO_CFG_MAX_SWING,
	parameter logic [4:0] CFG_MIN_SWING   = KEO_CFG_MIN_SWING,
	parameter logic [5:0] CFG_POST_CURSOR = KEO_CFG_POST_CURSOR,
	parameter logic [4:0] CFG_PRE_CURSOR  = KEO_CFG_PRE_CURSOR,
	parameter logic [4:0] CFG_PRESET_MAIN = KEO_CFG_PRESET_MAIN
) (
	input  wire logic        hclk,              // Bus clock, 200 MHz
	input  wire logic        hresetn,           // Async reset, active low
	input  wire logic        hsel,              // Slave select
	input  wire logic [31:0] haddr,             // Byte address
	input  wire logic [1:0]  htrans,            // Transfer type
	input  wire logic        hwrite,            // Write when high
	input  wire logic [2:0]  hsize,             // Transfer size
	input  wire logic [31:0] hwdata,            // Write data
	input  wire logic        hready,            // Bus ready in
	output logic             hreadyout,         // Slave ready out
	output logic [31:0]      hrdata,            // Read data
	output logic             hresp,             // Response, always OKAY
	input  wire logic        rxeq_valid,        // New receive eq settings
	input  wire logic [3:0]  linear_eq_setting, // Linear equalizer setting
	input  wire logic [1:0]  linear_eq_mode,    // Linear equalizer mode
	input  wire logic [1:0]  dfe_mode,          // Feedback equalizer mode
	input  wire logic        coef_valid,        // New trained tx taps
	input  wire logic [4:0]  coef_swing,        // Trained swing setting
	input  wire logic [5:0]  coef_post,         // Trained post-tap setting
	input  wire logic [4:0]  coef_pre,          // Trained pre-tap setting
	output logic [4:0]       max_swing_limit,   // Effective maximum swing
	output logic [4:0]       min_swing_limit,   // Effective minimum swing
	output logic [5:0]       post_cursor_limit, // Effective post-cursor limit
	output logic [4:0]       pre_cursor_limit,  // Effective pre-cursor limit
	output logic [4:0]       preset_main_tap    // Effective preset main tap
);

	// ------------------------------------------------------------------
	// Bus address phase
	// ------------------------------------------------------------------
	logic        acc_valid;
	logic        wr_pend;
	logic        next_wr_pend;
	logic [10:0] wr_idx;
	logic [10:0] next_wr_idx;
	logic [10:0] acc_idx;
	logic        acc_inrange;

	// Only the low word index is decoded; anything above it is unmapped.
	assign acc_valid   = hsel && hready && (htrans == KEO_HTRANS_NONSEQ);
	assign acc_idx     = haddr[12:2];
	assign acc_inrange = (haddr[31:13] == 19'h0);

	always_comb begin
		next_wr_pend = acc_valid && hwrite;
		next_wr_idx  = acc_inrange ? acc_idx : KEO_IDX_RSVD_LAST;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= 11'h000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_idx  <= next_wr_idx;
		end
	end

	// ------------------------------------------------------------------
	// Override word
	// ------------------------------------------------------------------
	logic [4:0] max_ovrd;
	logic       max_en;
	logic [4:0] min_ovrd;
	logic       min_en;
	logic [5:0] post_ovrd;
	logic       post_en;
	logic [4:0] pre_ovrd;
	logic       pre_en;
	logic [4:0] next_max_ovrd;
	logic       next_max_en;
	logic [4:0] next_min_ovrd;
	logic       next_min_en;
	logic [5:0] next_post_ovrd;
	logic       next_post_en;
	logic [4:0] next_pre_ovrd;
	logic       next_pre_en;
	logic       ovrd_wr;

	// The write lands at the end of the data phase, when hwdata is valid.
	assign ovrd_wr = wr_pend && (wr_idx == KEO_IDX_OVERRIDE);

	always_comb begin
		next_max_ovrd  = max_ovrd;
		next_max_en    = max_en;
		next_min_ovrd  = min_ovrd;
		next_min_en    = min_en;
		next_post_ovrd = post_ovrd;
		next_post_en   = post_en;
		next_pre_ovrd  = pre_ovrd;
		next_pre_en    = pre_en;
		if (ovrd_wr) begin
			next_max_ovrd  = hwdata[KEO_OV_MAX_LSB +: KEO_SWING_W];
			next_max_en    = hwdata[KEO_OV_MAX_EN];
			next_min_ovrd  = hwdata[KEO_OV_MIN_LSB +: KEO_SWING_W];
			next_min_en    = hwdata[KEO_OV_MIN_EN];
			next_post_ovrd = hwdata[KEO_OV_POST_LSB +: KEO_POST_W];
			next_post_en   = hwdata[KEO_OV_POST_EN];
			next_pre_ovrd  = hwdata[KEO_OV_PRE_LSB +: KEO_PRE_W];
			next_pre_en    = hwdata[KEO_OV_PRE_EN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			max_ovrd  <= KEO_OVERRIDE_RST[KEO_OV_MAX_LSB +: KEO_SWING_W];
			max_en    <= KEO_OVERRIDE_RST[KEO_OV_MAX_EN];
			min_ovrd  <= KEO_OVERRIDE_RST[KEO_OV_MIN_LSB +: KEO_SWING_W];
			min_en    <= KEO_OVERRIDE_RST[KEO_OV_MIN_EN];
			post_ovrd <= KEO_OVERRIDE_RST[KEO_OV_POST_LSB +: KEO_POST_W];
			post_en   <= KEO_OVERRIDE_RST[KEO_OV_POST_EN];
			pre_ovrd  <= KEO_OVERRIDE_RST[KEO_OV_PRE_LSB +: KEO_PRE_W];
			pre_en    <= KEO_OVERRIDE_RST[KEO_OV_PRE_EN];
		end else begin
			max_ovrd  <= next_max_ovrd;
			max_en    <= next_max_en;
			min_ovrd  <= next_min_ovrd;
			min_en    <= next_min_en;
			post_ovrd <= next_post_ovrd;
			post_en   <= next_post_en;
			pre_ovrd  <= next_pre_ovrd;
			pre_en    <= next_pre_en;
		end
	end

	// ------------------------------------------------------------------
	// Readback capture
	// ------------------------------------------------------------------
	logic [4:0] rb_swing;
	logic [5:0] rb_post;
	logic [4:0] rb_pre;
	logic [3:0] rb_ctle;
	logic [1:0] rb_lmode;
	logic [1:0] rb_dfe;
	logic [4:0] next_rb_swing;
	logic [5:0] next_rb_post;
	logic [4:0] next_rb_pre;
	logic [3:0] next_rb_ctle;
	logic [1:0] next_rb_lmode;
	logic [1:0] next_rb_dfe;

	// Each field keeps the last value issued; no write from the bus reaches it.
	always_comb begin
		next_rb_swing = rb_swing;
		next_rb_post  = rb_post;
		next_rb_pre   = rb_pre;
		next_rb_ctle  = rb_ctle;
		next_rb_lmode = rb_lmode;
		next_rb_dfe   = rb_dfe;
		if (coef_valid) begin
			next_rb_swing = coef_swing;
			next_rb_post  = coef_post;
			next_rb_pre   = coef_pre;
		end
		if (rxeq_valid) begin
			next_rb_ctle  = linear_eq_setting;
			next_rb_lmode = linear_eq_mode;
			next_rb_dfe   = dfe_mode;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rb_swing <= KEO_READBACK_RST[KEO_RB_SWING_LSB +: KEO_SWING_W];
			rb_post  <= KEO_READBACK_RST[KEO_RB_POST_LSB +: KEO_POST_W];
			rb_pre   <= KEO_READBACK_RST[KEO_RB_PRE_LSB +: KEO_PRE_W];
			rb_ctle  <= KEO_READBACK_RST[KEO_RB_CTLE_LSB +: KEO_CTLE_W];
			rb_lmode <= KEO_READBACK_RST[KEO_RB_LMODE_LSB +: KEO_MODE_W];
			rb_dfe   <= KEO_READBACK_RST[KEO_RB_DFE_LSB +: KEO_MODE_W];
		end else begin
			rb_swing <= next_rb_swing;
			rb_post  <= next_rb_post;
			rb_pre   <= next_rb_pre;
			rb_ctle  <= next_rb_ctle;
			rb_lmode <= next_rb_lmode;
			rb_dfe   <= next_rb_dfe;
		end
	end

	// ------------------------------------------------------------------
	// Read data path
	// ------------------------------------------------------------------
	logic [31:0] rb_word;
	logic [31:0] ov_word;
	logic [31:0] ov_fwd;
	logic [31:0] next_hrdata;

	always_comb begin
		rb_word = 32'h0000_0000;
		rb_word[KEO_RB_SWING_LSB +: KEO_SWING_W] = rb_swing;
		rb_word[KEO_RB_POST_LSB +: KEO_POST_W]   = rb_post;
		rb_word[KEO_RB_PRE_LSB +: KEO_PRE_W]     = rb_pre;
		rb_word[KEO_RB_CTLE_LSB +: KEO_CTLE_W]   = rb_ctle;
		rb_word[KEO_RB_LMODE_LSB +: KEO_MODE_W]  = rb_lmode;
		rb_word[KEO_RB_DFE_LSB +: KEO_MODE_W]    = rb_dfe;
	end

	// Unused override bits read as zero.
	always_comb begin
		ov_word = 32'h0000_0000;
		ov_word[KEO_OV_MAX_LSB +: KEO_SWING_W] = max_ovrd;
		ov_word[KEO_OV_MAX_EN]                 = max_en;
		ov_word[KEO_OV_MIN_LSB +: KEO_SWING_W] = min_ovrd;
		ov_word[KEO_OV_MIN_EN]                 = min_en;
		ov_word[KEO_OV_POST_LSB +: KEO_POST_W] = post_ovrd;
		ov_word[KEO_OV_POST_EN]                = post_en;
		ov_word[KEO_OV_PRE_LSB +: KEO_PRE_W]   = pre_ovrd;
		ov_word[KEO_OV_PRE_EN]                 = pre_en;
	end

	// A read issued right behind a write to the same word would otherwise
	// return the stale value, since the write only lands at this same edge.
	always_comb begin
		ov_fwd = ov_word;
		if (ovrd_wr) begin
			ov_fwd = 32'h0000_0000;
			ov_fwd[KEO_OV_MAX_LSB +: KEO_SWING_W] =
				hwdata[KEO_OV_MAX_LSB +: KEO_SWING_W];
			ov_fwd[KEO_OV_MAX_EN]  = hwdata[KEO_OV_MAX_EN];
			ov_fwd[KEO_OV_MIN_LSB +: KEO_SWING_W] =
				hwdata[KEO_OV_MIN_LSB +: KEO_SWING_W];
			ov_fwd[KEO_OV_MIN_EN]  = hwdata[KEO_OV_MIN_EN];
			ov_fwd[KEO_OV_POST_LSB +: KEO_POST_W] =
				hwdata[KEO_OV_POST_LSB +: KEO_POST_W];
			ov_fwd[KEO_OV_POST_EN] = hwdata[KEO_OV_POST_EN];
			ov_fwd[KEO_OV_PRE_LSB +: KEO_PRE_W] =
				hwdata[KEO_OV_PRE_LSB +: KEO_PRE_W];
			ov_fwd[KEO_OV_PRE_EN]  = hwdata[KEO_OV_PRE_EN];
		end
	end

	// Reserved and unmapped words read zero and ignore writes.
	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (acc_valid && !hwrite && acc_inrange) begin
			if (acc_idx == KEO_IDX_READBACK) begin
				next_hrdata = rb_word;
			end else if (acc_idx == KEO_IDX_OVERRIDE) begin
				next_hrdata = ov_fwd;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= KEO_HRESP_OKAY;
		end else begin
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= KEO_HRESP_OKAY;
		end
	end

	// ------------------------------------------------------------------
	// Effective limits
	// ------------------------------------------------------------------
	keo_lim_if #(.W(KEO_SWING_W)) max_if ();
	keo_lim_if #(.W(KEO_SWING_W)) min_if ();
	keo_lim_if #(.W(KEO_POST_W))  post_if ();
	keo_lim_if #(.W(KEO_PRE_W))   pre_if ();
	keo_lim_if #(.W(KEO_SWING_W)) main_if ();

	assign max_if.ovrd  = max_ovrd;
	assign max_if.en    = max_en;
	assign min_if.ovrd  = min_ovrd;
	assign min_if.en    = min_en;
	assign post_if.ovrd = post_ovrd;
	assign post_if.en   = post_en;
	assign pre_if.ovrd  = pre_ovrd;
	assign pre_if.en    = pre_en;
	// The maximum swing override doubles as the preset main tap.
	assign main_if.ovrd = max_ovrd;
	assign main_if.en   = max_en;

	keo_limit_sel #(.W(KEO_SWING_W), .CFG(CFG_MAX_SWING)) u_max (
		.hclk    (hclk),
		.hresetn (hresetn),
		.lim     (max_if.sel)
	);
	keo_limit_sel #(.W(KEO_SWING_W), .CFG(CFG_MIN_SWING)) u_min (
		.hclk    (hclk),
		.hresetn (hresetn),
		.lim     (min_if.sel)
	);
	keo_limit_sel #(.W(KEO_POST_W), .CFG(CFG_POST_CURSOR)) u_post (
		.hclk    (hclk),
		.hresetn (hresetn),
		.lim     (post_if.sel)
	);
	keo_limit_sel #(.W(KEO_PRE_W), .CFG(CFG_PRE_CURSOR)) u_pre (
		.hclk    (hclk),
		.hresetn (hresetn),
		.lim     (pre_if.sel)
	);
	keo_limit_sel #(.W(KEO_SWING_W), .CFG(CFG_PRESET_MAIN)) u_main (
		.hclk    (hclk),
		.hresetn (hresetn),
		.lim     (main_if.sel)
	);

	// Range checks against the initial taps are left to software.
	assign max_swing_limit   = max_if.lim;
	assign min_swing_limit   = min_if.lim;
	assign post_cursor_limit = post_if.lim;
	assign pre_cursor_limit  = pre_if.lim;
	assign preset_main_tap   = main_if.lim;

endmodule
`default_nettype wire

// ### dv/keo_lt_model.sv
// Behavioural model of the equalization and link-training logic.
`timescale 1ns/1ps
`default_nettype none
module keo_lt_model (
	input  wire logic        hclk,              // Bus clock
	input  wire logic        hresetn,           // Reset, active low
	input  wire logic        rx_go,             // Issue receive settings
	input  wire logic [7:0]  rx_word,           // Mode, mode and setting
	input  wire logic        co_go,             // Issue trained taps
	input  wire logic [15:0] co_word,           // Pre, post and swing
	output logic             rxeq_valid,        // Receive settings strobe
	output logic [3:0]       linear_eq_setting, // Linear equalizer setting
	output logic [1:0]       linear_eq_mode,    // Linear equalizer mode
	output logic [1:0]       dfe_mode,          // Feedback equalizer mode
	output logic             coef_valid,        // Trained taps strobe
	output logic [4:0]       coef_swing,        // Trained swing
	output logic [5:0]       coef_post,         // Trained post tap
	output logic [4:0]       coef_pre           // Trained pre tap
);
	logic [7:0]  rx_q;
	logic [15:0] co_q;

	assign {dfe_mode, linear_eq_mode, linear_eq_setting} = rx_q;
	assign {coef_pre, coef_post, coef_swing} = co_q;

	// Outside a strobe the lines toggle, so a stale capture cannot pass.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxeq_valid <= 1'b0;
			coef_valid <= 1'b0;
			rx_q <= 8'h00;
			co_q <= 16'h0000;
		end else begin
			rxeq_valid <= rx_go;
			coef_valid <= co_go;
			rx_q <= rx_go ? rx_word : ~rx_q;
			co_q <= co_go ? co_word : ~co_q;
		end
	end
endmodule
`default_nettype wire

// ### dv/keo_regs_monitor.sv
// Checker of bus answers, limit outputs and readback contents.
`timescale 1ns/1ps
`default_nettype none
module keo_regs_monitor
	import keo_pkg::*;
#(
	parameter logic [4:0] CFG_MAX_SWING   = KEO_CFG_MAX_SWING,
	parameter logic [4:0] CFG_MIN_SWING   = KEO_CFG_MIN_SWING,
	parameter logic [5:0] CFG_POST_CURSOR = KEO_CFG_POST_CURSOR,
	parameter logic [4:0] CFG_PRE_CURSOR  = KEO_CFG_PRE_CURSOR,
	parameter logic [4:0] CFG_PRESET_MAIN = KEO_CFG_PRESET_MAIN
) (
	input wire logic        hclk,              // Bus clock
	input wire logic        hresetn,           // Reset, active low
	input wire logic        hsel,              // Slave select
	input wire logic [31:0] haddr,             // Byte address
	input wire logic [1:0]  htrans,            // Transfer type
	input wire logic        hwrite,            // Write when high
	input wire logic [31:0] hwdata,            // Write data
	input wire logic        hready,            // Bus ready
	input wire logic        hreadyout,         // Slave ready
	input wire logic [31:0] hrdata,            // Read data
	input wire logic        hresp,             // Response
	input wire logic        rxeq_valid,        // Receive settings strobe
	input wire logic [3:0]  linear_eq_setting, // Linear eq setting
	input wire logic [1:0]  linear_eq_mode,    // Linear eq mode
	input wire logic [1:0]  dfe_mode,          // Feedback eq mode
	input wire logic        coef_valid,        // Trained taps strobe
	input wire logic [4:0]  coef_swing,        // Trained swing
	input wire logic [5:0]  coef_post,         // Trained post tap
	input wire logic [4:0]  coef_pre,          // Trained pre tap
	input wire logic [4:0]  max_swing_limit,   // Maximum swing out
	input wire logic [4:0]  min_swing_limit,   // Minimum swing out
	input wire logic [5:0]  post_cursor_limit, // Post-cursor out
	input wire logic [4:0]  pre_cursor_limit,  // Pre-cursor out
	input wire logic [4:0]  preset_main_tap    // Preset main tap out
);
	logic        take;
	logic        rd;
	logic        wr_pend;
	logic [31:0] ovr;
	logic [31:0] ovr_q;
	logic [31:0] rb;

	assign take = hsel && hready && htrans == KEO_HTRANS_NONSEQ;
	assign rd = take && !hwrite;

	// Shadow copies of both words, rebuilt from bus and capture traffic.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			ovr <= 32'h0;
			ovr_q <= 32'h0;
			rb <= 32'h0;
		end else begin
			wr_pend <= take && hwrite && haddr == KEO_ADDR_OVERRIDE;
			ovr <= wr_pend ? (hwdata & 32'h3f7f_3f3f) : ovr;
			ovr_q <= ovr;
			if (rxeq_valid)
				rb[31:24] <= {dfe_mode, linear_eq_mode, linear_eq_setting};
			if (coef_valid)
				rb[20:0] <= {coef_pre, 2'h0, coef_post, 3'h0, coef_swing};
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_BUS_OKAY: assert property (hreadyout && hresp == KEO_HRESP_OKAY)
		else $error("bus answer not ready or not okay");
	AST_MAX: assert property (
		max_swing_limit == (ovr_q[5] ? ovr_q[4:0] : CFG_MAX_SWING))
		else $error("maximum swing limit wrong");
	AST_PRESET: assert property (
		preset_main_tap == (ovr_q[5] ? ovr_q[4:0] : CFG_PRESET_MAIN))
		else $error("preset main tap wrong");
	AST_MIN: assert property (
		min_swing_limit == (ovr_q[13] ? ovr_q[12:8] : CFG_MIN_SWING))
		else $error("minimum swing limit wrong");
	AST_POST: assert property (
		post_cursor_limit == (ovr_q[22] ? ovr_q[21:16] : CFG_POST_CURSOR))
		else $error("post-cursor limit wrong");
	AST_PRE: assert property (
		pre_cursor_limit == (ovr_q[29] ? ovr_q[28:24] : CFG_PRE_CURSOR))
		else $error("pre-cursor limit wrong");
	AST_OVR_RD: assert property (
		rd && haddr == KEO_ADDR_OVERRIDE |=> hrdata == ovr)
		else $error("override word read wrong");
	AST_RB_RD: assert property (
		rd && haddr == KEO_ADDR_READBACK |=> hrdata == $past(rb))
		else $error("readback word read wrong");
	AST_RSV_RD: assert property (
		rd && haddr[12:2] > KEO_IDX_OVERRIDE |=> hrdata == 32'h0)
		else $error("reserved word not zero");

	COV_OVR_WR: cover property (take && hwrite && haddr == KEO_ADDR_OVERRIDE);
	COV_RB_RD: cover property (rxeq_valid ##2 rd);
	COV_RSV_RD: cover property (rd && haddr[12:2] > KEO_IDX_OVERRIDE);
endmodule

bind keo_regs keo_regs_monitor #(
	.CFG_MAX_SWING(CFG_MAX_SWING), .CFG_MIN_SWING(CFG_MIN_SWING),
	.CFG_POST_CURSOR(CFG_POST_CURSOR), .CFG_PRE_CURSOR(CFG_PRE_CURSOR),
	.CFG_PRESET_MAIN(CFG_PRESET_MAIN)
) keo_regs_monitor_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.rxeq_valid(rxeq_valid), .linear_eq_setting(linear_eq_setting),
	.linear_eq_mode(linear_eq_mode), .dfe_mode(dfe_mode),
	.coef_valid(coef_valid), .coef_swing(coef_swing),
	.coef_post(coef_post), .coef_pre(coef_pre),
	.max_swing_limit(max_swing_limit), .min_swing_limit(min_swing_limit),
	.post_cursor_limit(post_cursor_limit),
	.pre_cursor_limit(pre_cursor_limit), .preset_main_tap(preset_main_tap)
);
`default_nettype wire

// ### dv/keo_regs_tb_top.sv
// Self-checking bench for the equalization override register bank.
`timescale 1ns/1ps
`default_nettype none
module keo_regs_tb_top;
	import keo_pkg::*;
	localparam logic [4:0] T_MAX = 5'h1a;
	localparam logic [4:0] T_MIN = 5'h03;
	localparam logic [5:0] T_POST = 6'h14;
	localparam logic [4:0] T_PRE = 5'h07;
	localparam logic [4:0] T_PRESET = 5'h11;
	localparam logic [31:0] ENS [7] = '{32'h0, 32'h20, 32'h2000,
		32'h40_0000, 32'h2000_0000, 32'h2040_2020, 32'h0};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic rxeq_valid, coef_valid, rx_go, co_go;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, linear_eq_mode, dfe_mode;
	logic [2:0] hsize;
	logic [3:0] linear_eq_setting;
	logic [4:0] coef_swing, coef_pre, max_lim, min_lim, pre_lim, preset;
	logic [5:0] coef_post, post_lim;
	logic [7:0] rx_word, erx;
	logic [15:0] co_word, eco;
	int mismatches, compares, cycles;

	keo_regs #(.CFG_MAX_SWING(T_MAX), .CFG_MIN_SWING(T_MIN),
		.CFG_POST_CURSOR(T_POST), .CFG_PRE_CURSOR(T_PRE),
		.CFG_PRESET_MAIN(T_PRESET)) keo_regs_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .rxeq_valid(rxeq_valid),
		.linear_eq_setting(linear_eq_setting),
		.linear_eq_mode(linear_eq_mode), .dfe_mode(dfe_mode),
		.coef_valid(coef_valid), .coef_swing(coef_swing),
		.coef_post(coef_post), .coef_pre(coef_pre),
		.max_swing_limit(max_lim), .min_swing_limit(min_lim),
		.post_cursor_limit(post_lim), .pre_cursor_limit(pre_lim),
		.preset_main_tap(preset));
	keo_lt_model keo_lt_model_inst (.hclk(hclk), .hresetn(hresetn),
		.rx_go(rx_go), .rx_word(rx_word), .co_go(co_go),
		.co_word(co_word), .rxeq_valid(rxeq_valid),
		.linear_eq_setting(linear_eq_setting),
		.linear_eq_mode(linear_eq_mode), .dfe_mode(dfe_mode),
		.coef_valid(coef_valid), .coef_swing(coef_swing),
		.coef_post(coef_post), .coef_pre(coef_pre));

	always #2.5 hclk = ~hclk;

	// ----------------------------------------------------------------
	// Bus and comparison helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask

	// Flop outputs read right at the edge still show their pre-edge value.
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= KEO_HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0, r);
	endtask

	function automatic logic [31:0] lims(input logic [31:0] o);
		return {6'h0, o[29] ? o[28:24] : T_PRE, o[22] ? o[21:16] : T_POST,
			o[13] ? o[12:8] : T_MIN, o[5] ? o[4:0] : T_MAX,
			o[5] ? o[4:0] : T_PRESET};
	endfunction

	task automatic lim_chk(input logic [31:0] o);
		logic [31:0] g;
		@(posedge hclk);
		@(negedge hclk);
		g = {6'h0, pre_lim, post_lim, min_lim, max_lim, preset};
		check(g, lims(o));
		@(posedge hclk);
	endtask

	task automatic send(input logic rg, input logic cg,
		input logic [7:0] rw, input logic [15:0] cw);
		rx_go <= rg;
		co_go <= cg;
		rx_word <= rw;
		co_word <= cw;
		erx = rg ? rw : erx;
		eco = cg ? cw : eco;
		@(posedge hclk);
		rx_go <= 1'b0;
		co_go <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		rd(KEO_ADDR_OVERRIDE, r);
		check(r, 32'h0);
		rd(KEO_ADDR_READBACK, r);
		check(r, 32'h0);
		lim_chk(32'h0);
	endtask

	// Every enable alone, all together, then all off again.
	task automatic t_override();
		logic [31:0] r, o;
		for (int i = 0; i < 7; i++) begin
			// Values sit above the initial taps and within the swing bounds;
			// the first pass stores them with every enable still off.
			o = 32'h192d_0b1c | ENS[i];
			wr(KEO_ADDR_OVERRIDE, o | 32'hc080_c0c0);
			rd(KEO_ADDR_OVERRIDE, r);
			check(r, o);
			lim_chk(o);
		end
	endtask

	task automatic t_readback();
		logic [31:0] r, e;
		send(1'b1, 1'b1, 8'hb6, 16'hd5b3);
		for (int i = 0; i < 4; i++) begin
			if (i == 1)
				wr(KEO_ADDR_READBACK, 32'hffff_ffff);
			if (i == 2)
				send(1'b1, 1'b0, 8'h49, 16'h2a4c);
			if (i == 3)
				send(1'b0, 1'b1, 8'h00, 16'h2a4c);
			rd(KEO_ADDR_READBACK, r);
			e = {erx, 3'h0, eco[15:11], 2'h0, eco[10:5], 3'h0, eco[4:0]};
			check(r, e);
		end
	endtask

	task automatic t_reserved();
		logic [31:0] r;
		logic [31:0] a [4];
		a = '{32'h135c, 32'h13a4, 32'h13fc, 32'h3358};
		foreach (a[i]) begin
			wr(a[i], 32'hffff_ffff);
			rd(a[i], r);
			check(r, 32'h0);
		end
		rd(KEO_ADDR_OVERRIDE, r);
		check(r, 32'h192d_0b1c);
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		{hclk, hresetn, hsel, hwrite, rx_go, co_go} = 6'h0;
		{haddr, hwdata, htrans, rx_word, co_word} = '0;
		{erx, eco} = 24'h0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_override();
		t_readback();
		t_reserved();
		wrap_up();
	end
endmodule
`default_nettype wire
